// [verilog/pac_top.sv]
// power and audio format control registers with clip and power logic
`timescale 1ns/1ps
`default_nettype none
module pac_top
  import pac_pkg::*;
#(
  parameter int RAMP_STEPS = pac_pkg::PAC_RAMP_STEPS
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic [7:0]                     reg_rdata,
  input  wire logic                      shutdown_n,
  input  wire logic [pac_pkg::PAC_SLOT_W-1:0] dev_addr_slot,
  input  wire logic [pac_pkg::PAC_SLOT_W-1:0] slot_index,
  input  wire logic                      dc_detect,
  input  wire logic                      fault_clear,
  input  wire logic                      smp_valid,
  input  wire logic [pac_pkg::PAC_CLIP_W-1:0] smp_in,
  output logic                           conv_valid,
  output logic [pac_pkg::PAC_CLIP_W-1:0] conv_sample,
  output logic                           highpass_skip,
  output logic                           rate_double,
  output logic [2:0]                     serial_audio_format,
  output logic [pac_pkg::PAC_SLOT_W-1:0] play_slot,
  output logic                           ramp_down,
  output logic                           stage_hiz,
  output logic                           in_shutdown,
  output logic                           in_sleep,
  output logic                           dc_fault
);
  logic [7:0] power_clip_high_control_ff;
  logic [7:0] nxt_power_clip_high_control;
  logic [7:0] digital_format_control_ff;
  logic [7:0] nxt_digital_format_control;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  pac_pwr_e   pwr_ff;
  pac_pwr_e   nxt_pwr;
  logic [7:0] ramp_ff;
  logic [7:0] nxt_ramp;
  logic       dc_fault_ff;
  logic       nxt_dc_fault;
  logic       shdn_req;
  logic       sleep_req;
  logic [PAC_CLIP_W-1:0] clip_threshold;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // register file; runs regardless of power state
  always_comb begin
    nxt_power_clip_high_control = power_clip_high_control_ff;
    nxt_digital_format_control  = digital_format_control_ff;
    nxt_rdata                   = rdata_ff;
    if (reg_wr && hit(reg_addr, PAC_OFS_POWER)) begin
      nxt_power_clip_high_control = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, PAC_OFS_FORMAT)) begin
      // reserved bits held at zero whatever the host writes
      nxt_digital_format_control = reg_wdata & PAC_FMT_WMASK;
    end
    if (reg_rd) begin
      if (hit(reg_addr, PAC_OFS_POWER)) begin
        nxt_rdata = power_clip_high_control_ff;
      end else if (hit(reg_addr, PAC_OFS_FORMAT)) begin
        nxt_rdata = digital_format_control_ff;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_clip_high_control_ff <= PAC_RST_POWER;
      digital_format_control_ff  <= PAC_RST_FORMAT;
      rdata_ff                   <= 8'h00;
    end else begin
      power_clip_high_control_ff <= nxt_power_clip_high_control;
      digital_format_control_ff  <= nxt_digital_format_control;
      rdata_ff                   <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // decoded controls
  assign shdn_req  = ~power_clip_high_control_ff[PAC_POW_SHDN]
                     | ~shutdown_n;
  assign sleep_req = power_clip_high_control_ff[PAC_POW_SLEEP];
  assign highpass_skip = digital_format_control_ff[PAC_FMT_HPSKIP];
  assign rate_double   = digital_format_control_ff[PAC_FMT_RATE];
  // codes 6 and 7 are passed as is; host keeps off them
  assign serial_audio_format =
    digital_format_control_ff[PAC_FMT_FMT_HI:PAC_FMT_FMT_LO];
  assign play_slot = digital_format_control_ff[PAC_FMT_SLOTSRC]
                     ? slot_index : dev_addr_slot;

  assign clip_threshold = {
    power_clip_high_control_ff[PAC_POW_CLIP_HI:PAC_POW_CLIP_LO],
    PAC_CLIP_LOW_RST};

  // power state: ramp before hi-z, shutdown overrides
  always_comb begin
    nxt_pwr  = pwr_ff;
    nxt_ramp = ramp_ff;
    case (pwr_ff)
      PAC_RUN: begin
        if (shdn_req) begin
          nxt_pwr = PAC_SHDN;
        end else if (sleep_req) begin
          nxt_pwr  = PAC_RAMP;
          nxt_ramp = 8'(RAMP_STEPS - 1);
        end
      end
      PAC_RAMP: begin
        if (shdn_req) begin
          nxt_pwr = PAC_SHDN;
        end else if (!sleep_req) begin
          nxt_pwr = PAC_RUN;
        end else if (ramp_ff == 8'h00) begin
          nxt_pwr = PAC_SLEEP;
        end else begin
          nxt_ramp = ramp_ff - 8'h01;
        end
      end
      PAC_SLEEP: begin
        if (shdn_req) begin
          nxt_pwr = PAC_SHDN;
        end else if (!sleep_req) begin
          nxt_pwr = PAC_RUN;
        end
      end
      PAC_SHDN: begin
        if (!shdn_req) begin
          nxt_pwr = PAC_RUN;
        end
      end
      default: begin
        nxt_pwr = PAC_SHDN;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwr_ff  <= PAC_RUN;
      ramp_ff <= 8'h00;
    end else begin
      pwr_ff  <= nxt_pwr;
      ramp_ff <= nxt_ramp;
    end
  end

  assign ramp_down   = pwr_ff == PAC_RAMP;
  assign stage_hiz   = pwr_ff == PAC_SLEEP || pwr_ff == PAC_SHDN;
  assign in_sleep    = pwr_ff == PAC_SLEEP;
  assign in_shutdown = pwr_ff == PAC_SHDN;

  // dc fault latches until explicit clear; set wins
  always_comb begin
    nxt_dc_fault = dc_fault_ff;
    if (fault_clear) begin
      nxt_dc_fault = 1'b0;
    end
    if (dc_detect) begin
      nxt_dc_fault = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dc_fault_ff <= 1'b0;
    end else begin
      dc_fault_ff <= nxt_dc_fault;
    end
  end

  assign dc_fault = dc_fault_ff;

  pac_clipper #(
    .W (PAC_CLIP_W)
  ) pac_clipper_inst (
    .mclk       (mclk),
    .rst        (rst),
    .in_valid   (smp_valid),
    .in_sample  (smp_in),
    .threshold  (clip_threshold),
    .out_valid  (conv_valid),
    .out_sample (conv_sample)
  );

  a_pow_write: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == PAC_OFS_POWER |=>
    power_clip_high_control_ff == $past(reg_wdata))
    else $error("power register write lost");
  a_fmt_rsv: assert property (@(posedge mclk) disable iff (rst)
    digital_format_control_ff[5:4] == 2'b00)
    else $error("reserved format bits set");
  a_shdn_enter: assert property (@(posedge mclk) disable iff (rst)
    !shutdown_n |=> in_shutdown)
    else $error("shutdown pin ignored");
  a_shdn_pin: assert property (@(posedge mclk) disable iff (rst)
    !shutdown_n ##1 !shutdown_n |-> in_shutdown)
    else $error("not in shutdown with pin low");
  a_sleep_ramp: assert property (@(posedge mclk) disable iff (rst)
    $rose(in_sleep) |-> $past(ramp_down))
    else $error("sleep entered without ramp");
  a_slot_sel: assert property (@(posedge mclk) disable iff (rst)
    play_slot == (digital_format_control_ff[6] ? slot_index
                  : dev_addr_slot))
    else $error("wrong playback slot");
  a_dc_latch: assert property (@(posedge mclk) disable iff (rst)
    dc_detect |=> dc_fault [*2] or fault_clear)
    else $error("dc fault not latched");
  a_read_back: assert property (@(posedge mclk) disable iff (rst)
    reg_rd && reg_addr == PAC_OFS_FORMAT |=>
    reg_rdata == $past(digital_format_control_ff))
    else $error("format readback wrong");
  a_regs_kept: assert property (@(posedge mclk) disable iff (rst)
    in_shutdown && !reg_wr |=> $stable(power_clip_high_control_ff))
    else $error("register changed in shutdown");
  a_shdn_bit: assert property (@(posedge mclk) disable iff (rst)
    !power_clip_high_control_ff[PAC_POW_SHDN] |=> in_shutdown)
    else $error("shutdown bit ignored");
  a_shdn_exit: assert property (@(posedge mclk) disable iff (rst)
    in_shutdown && !shdn_req |=> !in_shutdown)
    else $error("shutdown not left");
  a_fmt_write: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == PAC_OFS_FORMAT |=>
    digital_format_control_ff == ($past(reg_wdata) & PAC_FMT_WMASK))
    else $error("format register write lost");
  a_pow_read: assert property (@(posedge mclk) disable iff (rst)
    reg_rd && reg_addr == PAC_OFS_POWER |=>
    reg_rdata == $past(power_clip_high_control_ff))
    else $error("power readback wrong");
  a_rdata_hold: assert property (@(posedge mclk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_run_sleep: assert property (@(posedge mclk) disable iff (rst)
    pwr_ff == PAC_RUN && sleep_req && !shdn_req |=> ramp_down)
    else $error("sleep request did not start ramp");
  a_ramp_step: assert property (@(posedge mclk) disable iff (rst)
    ramp_down && ramp_ff != 8'h00 && sleep_req && !shdn_req
    |=> ramp_down)
    else $error("ramp ended early");
  a_sleep_exit: assert property (@(posedge mclk) disable iff (rst)
    in_sleep && !sleep_req && !shdn_req |=> !stage_hiz)
    else $error("sleep not left");
  a_dc_clear: assert property (@(posedge mclk) disable iff (rst)
    fault_clear && !dc_detect |=> !dc_fault)
    else $error("dc fault not cleared");

  // ramp length watch for the sleep entry check
  logic [7:0] ramp_seen_ff;
  logic [7:0] nxt_ramp_seen;

  always_comb begin
    nxt_ramp_seen = 8'h00;
    if (pwr_ff == PAC_RAMP) begin
      nxt_ramp_seen = ramp_seen_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ramp_seen_ff <= 8'h00;
    end else begin
      ramp_seen_ff <= nxt_ramp_seen;
    end
  end

  a_ramp_len: assert property (@(posedge mclk) disable iff (rst)
    $rose(in_sleep) |-> ramp_seen_ff == 8'(RAMP_STEPS))
    else $error("sleep ramp length wrong");
endmodule
`default_nettype wire

// [verilog/pac_pkg.sv]
// constants for the power and audio format control registers
package pac_pkg;
  localparam logic [7:0] PAC_OFS_POWER   = 8'h01;
  localparam logic [7:0] PAC_OFS_FORMAT  = 8'h02;
  localparam logic [7:0] PAC_OFS_SLOT    = 8'h03;
  localparam logic [7:0] PAC_RST_POWER   = 8'hFD;
  localparam logic [7:0] PAC_RST_FORMAT  = 8'h04;
  localparam int         PAC_POW_CLIP_HI = 7;
  localparam int         PAC_POW_CLIP_LO = 2;
  localparam int         PAC_POW_SLEEP   = 1;
  localparam int         PAC_POW_SHDN    = 0;
  localparam int         PAC_FMT_HPSKIP  = 7;
  localparam int         PAC_FMT_SLOTSRC = 6;
  localparam int         PAC_FMT_RATE    = 3;
  localparam int         PAC_FMT_FMT_HI  = 2;
  localparam int         PAC_FMT_FMT_LO  = 0;
  localparam logic [7:0] PAC_FMT_WMASK   = 8'hCF;
  localparam int         PAC_CLIP_W      = 20;
  localparam int         PAC_SLOT_W      = 3;
  localparam logic [PAC_CLIP_W-7:0] PAC_CLIP_LOW_RST = 14'h3FFF;
  localparam logic [2:0] PAC_SAF_RJ24    = 3'h0;
  localparam logic [2:0] PAC_SAF_RJ20    = 3'h1;
  localparam logic [2:0] PAC_SAF_RJ18    = 3'h2;
  localparam logic [2:0] PAC_SAF_RJ16    = 3'h3;
  localparam logic [2:0] PAC_SAF_I2S     = 3'h4;
  localparam logic [2:0] PAC_SAF_LJ      = 3'h5;
  localparam int         PAC_RAMP_STEPS  = 16;
  typedef enum logic [1:0] {PAC_RUN, PAC_RAMP, PAC_SLEEP, PAC_SHDN} pac_pwr_e;
endpackage

// [verilog/pac_clipper.sv]
// sample magnitude limiter
`timescale 1ns/1ps
`default_nettype none
module pac_clipper
  import pac_pkg::*;
#(
  parameter int W = pac_pkg::PAC_CLIP_W
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_sample,
  input  wire logic [W-1:0] threshold,
  output logic              out_valid,
  output logic [W-1:0]      out_sample
);
  logic [W-1:0] nxt_out_sample;
  logic [W-1:0] out_sample_ff;
  logic         out_valid_ff;
  logic [W-1:0] mag;
  logic [W-1:0] thr;

  always_comb begin
    thr = threshold;
    if (thr[W-1]) begin
      thr = {1'b0, {(W-1){1'b1}}};
    end
    mag = in_sample[W-1] ? W'(~in_sample + 1'b1) : in_sample;
    nxt_out_sample = in_sample;
    if (mag > thr) begin
      nxt_out_sample = in_sample[W-1] ? W'(~thr + 1'b1) : thr;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_sample_ff <= '0;
      out_valid_ff  <= 1'b0;
    end else begin
      out_valid_ff <= in_valid;
      if (in_valid) begin
        out_sample_ff <= nxt_out_sample;
      end
    end
  end

  assign out_sample = out_sample_ff;
  assign out_valid  = out_valid_ff;

  a_clip_bound: assert property (@(posedge mclk) disable iff (rst)
    out_valid |-> ((out_sample[W-1] ? W'(~out_sample + 1'b1) : out_sample)
      <= $past(thr)))
    else $error("clipped sample exceeds threshold");
endmodule
`default_nettype wire

// [sim/pac_host.sv]
// host side model driving the register access port
`timescale 1ns/1ps
`default_nettype none
module pac_host
  import pac_pkg::*;
(
  input  wire logic       mclk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  import pac_pkg::*;
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a === PAC_OFS_FORMAT) begin
      v[5:4] = 2'h0;
      if (v[2:1] === 2'h3) return; // reserved codes never sent
    end
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
    @(posedge mclk);
    #1;
  endtask
endmodule
`default_nettype wire

// [sim/pac_top_tb.sv]
// self-checking bench for the power and format control registers
`timescale 1ns/1ps
`default_nettype none
module pac_top_tb;
  import pac_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, shutdown_n = 1'b1;
  logic reg_wr, reg_rd, smp_valid = 1'b0, dc_detect = 1'b0;
  logic fault_clear = 1'b0, conv_valid, highpass_skip, rate_double;
  logic ramp_down, stage_hiz, in_shutdown, in_sleep, dc_fault;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
  logic [2:0]  dev_addr_slot = 3'h5, slot_index = 3'h2, c;
  logic [2:0]  serial_audio_format, play_slot;
  logic [19:0] smp_in = 20'h00000, conv_sample;
  int mismatches = 0, check_count = 0, cycles = 0, n;
  localparam int RAMP_N = 4;
  always #12.5 mclk = ~mclk;
  pac_top #(.RAMP_STEPS(RAMP_N)) pac_top_inst (.mclk(mclk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .shutdown_n(shutdown_n),
    .dev_addr_slot(dev_addr_slot), .slot_index(slot_index),
    .dc_detect(dc_detect), .fault_clear(fault_clear),
    .smp_valid(smp_valid), .smp_in(smp_in), .conv_valid(conv_valid),
    .conv_sample(conv_sample), .highpass_skip(highpass_skip),
    .rate_double(rate_double), .serial_audio_format(serial_audio_format),
    .play_slot(play_slot), .ramp_down(ramp_down), .stage_hiz(stage_hiz),
    .in_shutdown(in_shutdown), .in_sleep(in_sleep), .dc_fault(dc_fault));
  pac_host pac_host_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 4000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input string s, input logic [19:0] e, logic [19:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    pac_host_inst.rd(a, rv);
    chk("reg_rdata", {12'h000, e}, {12'h000, rv});
  endtask
  task automatic smp(input logic [19:0] x, input logic [19:0] e);
    smp_in = x;
    smp_valid = 1'b1;
    tick(1);
    smp_valid = 1'b0;
    chk("conv_valid", 20'h1, {19'h0, conv_valid});
    chk("conv_sample", e, conv_sample);
    tick(1);
    chk("conv_valid", 20'h0, {19'h0, conv_valid});
  endtask
  initial begin
    tick(20);
    rst = 1'b0;
    rchk(PAC_OFS_POWER, 8'hFD);
    rchk(PAC_OFS_FORMAT, 8'h04);
    rchk(8'h05, 8'h00);
    chk("highpass_skip", 20'h0, {19'h0, highpass_skip});
    chk("in_shutdown", 20'h0, {19'h0, in_shutdown});
    $display("test reset_values done");
    for (int i = 0; i < 6; i++) begin
      c = i[2:0];
      pac_host_inst.wr(PAC_OFS_FORMAT, {c[0], c[1], 2'h3, c[1], c});
      chk("serial_audio_format", {17'h0, c},
          {17'h0, serial_audio_format});
      chk("highpass_skip", {19'h0, c[0]}, {19'h0, highpass_skip});
      chk("rate_double", {19'h0, c[1]}, {19'h0, rate_double});
      chk("play_slot", {17'h0, c[1] ? 3'h2 : 3'h5},
          {17'h0, play_slot});
      rchk(PAC_OFS_FORMAT, {c[0], c[1], 2'h0, c[1], c});
    end
    $display("test format_codes done");
    pac_host_inst.wr(PAC_OFS_POWER, 8'h0D);
    rchk(PAC_OFS_POWER, 8'h0D);
    smp(20'h7FFFF, 20'h0FFFF);
    smp(20'h80000, 20'hF0001);
    smp(20'h00123, 20'h00123);
    $display("test clipper done");
    pac_host_inst.wr(PAC_OFS_POWER, 8'hFF);
    n = 0;
    while (ramp_down !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    n = 0;
    while (ramp_down === 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk("ramp_cycles", 20'(RAMP_N), n[19:0]);
    chk("in_sleep", 20'h1, {19'h0, in_sleep});
    chk("stage_hiz", 20'h1, {19'h0, stage_hiz});
    chk("in_shutdown", 20'h0, {19'h0, in_shutdown});
    pac_host_inst.wr(PAC_OFS_POWER, 8'hFD);
    tick(2);
    chk("in_sleep", 20'h0, {19'h0, in_sleep});
    $display("test sleep done");
    pac_host_inst.wr(PAC_OFS_POWER, 8'hFC);
    tick(1);
    chk("in_shutdown", 20'h1, {19'h0, in_shutdown});
    chk("stage_hiz", 20'h1, {19'h0, stage_hiz});
    pac_host_inst.wr(PAC_OFS_FORMAT, 8'h83);
    rchk(PAC_OFS_FORMAT, 8'h83);
    rchk(PAC_OFS_POWER, 8'hFC);
    pac_host_inst.wr(PAC_OFS_POWER, 8'hFD);
    tick(1);
    chk("in_shutdown", 20'h0, {19'h0, in_shutdown});
    shutdown_n = 1'b0;
    tick(2);
    chk("in_shutdown", 20'h1, {19'h0, in_shutdown});
    shutdown_n = 1'b1;
    tick(2);
    chk("in_shutdown", 20'h0, {19'h0, in_shutdown});
    $display("test shutdown done");
    dc_detect = 1'b1;
    tick(1);
    dc_detect = 1'b0;
    tick(5);
    chk("dc_fault", 20'h1, {19'h0, dc_fault});
    dc_detect = 1'b1;
    fault_clear = 1'b1;
    tick(1);
    dc_detect = 1'b0;
    chk("dc_fault", 20'h1, {19'h0, dc_fault});
    tick(1);
    fault_clear = 1'b0;
    tick(1);
    chk("dc_fault", 20'h0, {19'h0, dc_fault});
    $display("test dc_fault done");
    pac_host_inst.wr(PAC_OFS_POWER, 8'h06);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    rchk(PAC_OFS_POWER, 8'hFD);
    rchk(PAC_OFS_FORMAT, 8'h04);
    $display("test second_reset done");
    conclude();
  end
endmodule
`default_nettype wire
